// ### hw/lp_output_if.sv
// Purpose: Line printer output interface with DMA fetch and APB registers
// Assumes: Straps and printer status are pins; DMA and I/O commands are on pclk
// Notes: One character per DMA word, taken from the low byte
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/100ps
module lp_output_if
  import lp_pkg::*;
(
  input wire logic pclk,                  // Clock
  input wire logic presetn,               // Async reset, active low
  input wire logic psel,                  // APB select
  input wire logic penable,               // APB enable
  input wire logic pwrite,                // APB direction
  input wire logic [7:0] paddr,           // APB byte address
  input wire logic [31:0] pwdata,         // APB write data
  output logic [31:0] prdata,             // APB read data
  output logic pready,                    // APB ready
  output logic pslverr,                   // APB error
  input wire iocmd_type iocmd,            // Host I/O instruction
  output logic dma_req,                   // DMA read request, level
  output logic [ADDR_W-1:0] dma_addr,     // DMA word address
  input wire logic dma_ack,               // DMA data valid pulse
  input wire logic [15:0] dma_rdata,      // DMA read word
  input wire strap_type straps,           // Strap and switch pins
  input wire logic lp_ack_pin,            // Printer acknowledge pin
  input wire logic lp_online_pin,         // Printer on-line pin
  input wire logic lp_nopaper_pin,        // Printer no-paper pin
  output logic [7:0] lp_data_pin,         // Printer data pins
  output logic lp_strobe_pin,             // Printer data strobe pin
  output logic lp_plot_pin,               // Print/plot pin
  output logic irq                        // Interrupt, level
);

  // ****************************************************************
  // State record
  // ****************************************************************
  typedef struct packed {
    lp_state_type st;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] count;
    logic [7:0] chr;
    logic [CNT_W-1:0] cnt;
    logic vfu_pend;
    logic plot;
    logic strobe;
    logic [NUM_EVT-1:0] int_st;
    logic [NUM_EVT-1:0] int_msk;
    logic online_prev;
    logic nopaper_prev;
  } regs_type;

  regs_type r_q;
  regs_type r_d;
  strap_type sp;
  logic ack_s;
  logic online_s;
  logic nopaper_s;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  lp_sync #(
    .WIDTH($bits(strap_type) + 3)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({straps, lp_ack_pin, lp_online_pin, lp_nopaper_pin}),
    .sync_out({sp, ack_s, online_s, nopaper_s})
  );

  // ****************************************************************
  // Decoded straps
  // ****************************************************************
  logic [5:0] dev_code;
  logic ack_true;
  logic online_true;
  logic nopaper_true;
  logic [CNT_W-1:0] strobe_cyc;
  logic hit;
  logic is_lf;
  logic is_cr;
  logic is_vfu;
  logic skip;
  logic [7:0] rchr;

  // Switch level high means OFF, which is a one
  assign dev_code = sp.dev_switch;
  assign hit = iocmd.valid && (iocmd.code == dev_code);
  assign ack_true = ack_s ~^ sp.ack_true_hi;
  assign online_true = online_s ~^ sp.online_true_hi;
  assign nopaper_true = nopaper_s ~^ sp.nopaper_true_hi;

  // Strobe width, standard when no switch is on
  always_comb begin
    if (sp.strobe_width[0]) begin
      strobe_cyc = CNT_W'(STB_CYC_0);
    end else if (sp.strobe_width[2]) begin
      strobe_cyc = CNT_W'(STB_CYC_2);
    end else if (sp.strobe_width[3]) begin
      strobe_cyc = CNT_W'(STB_CYC_3);
    end else begin
      strobe_cyc = CNT_W'(STB_CYC_1);
    end
  end

  // Character filtering on the fetched byte
  assign rchr = dma_rdata[7:0];
  assign is_lf = (rchr == CH_LINE_FEED);
  assign is_cr = (rchr == CH_CARR_RET);
  assign is_vfu = (sp.vfu_code_a && rchr == CH_VFU_A) || (sp.vfu_code_b && rchr == CH_VFU_B);
  assign skip = (sp.mask_line_feed && is_lf)
    || (sp.mask_carr_ret && is_cr)
    || (r_q.vfu_pend && (sp.mask_vfu_a || sp.mask_vfu_b));

  // ****************************************************************
  // APB access
  // ****************************************************************
  logic acc;
  logic wr;
  logic rd;
  logic mapped;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) || (paddr == OFS_DMA_ADDR)
    || (paddr == OFS_DMA_COUNT) || (paddr == OFS_INT_STATUS) || (paddr == OFS_INT_MASK);
  assign pslverr = acc && !mapped;

  // Read data mux, unmapped reads zero
  always_comb begin
    prdata = '0;
    unique case (paddr)
      OFS_CTRL: prdata[0] = r_q.plot;
      OFS_STATUS: prdata = {18'h00000, dev_code, 4'h0, nopaper_true, online_true,
        r_q.st != ST_IDLE, r_q.int_st[EVT_DONE]};
      OFS_DMA_ADDR: prdata[ADDR_W-1:0] = r_q.addr;
      OFS_DMA_COUNT: prdata[ADDR_W-1:0] = r_q.count;
      OFS_INT_STATUS: prdata[NUM_EVT-1:0] = r_q.int_st;
      OFS_INT_MASK: prdata[NUM_EVT-1:0] = r_q.int_msk;
      default: prdata = '0;
    endcase
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic [NUM_EVT-1:0] evt;
    evt = '0;
    r_d = r_q;
    r_d.online_prev = online_true;
    r_d.nopaper_prev = nopaper_true;

    // Register writes
    if (wr) begin
      unique case (paddr)
        OFS_CTRL: r_d.plot = pwdata[0];
        OFS_DMA_ADDR: r_d.addr = pwdata[ADDR_W-1:0];
        OFS_DMA_COUNT: r_d.count = pwdata[ADDR_W-1:0];
        OFS_INT_MASK: r_d.int_msk = pwdata[NUM_EVT-1:0];
        default: ;
      endcase
    end

    // Transfer sequencer
    unique case (r_q.st)
      ST_IDLE: begin
        if (hit && iocmd.start) begin
          r_d.vfu_pend = 1'b0;
          if (r_q.count == '0) begin
            evt[EVT_DONE] = 1'b1;
          end else begin
            r_d.st = ST_FETCH;
          end
        end
      end
      ST_FETCH: begin
        if (dma_ack) begin
          r_d.addr = r_q.addr + ADDR_W'(1);
          r_d.count = r_q.count - ADDR_W'(1);
          r_d.vfu_pend = is_vfu;
          r_d.chr = rchr;
          if (!skip) begin
            r_d.st = ST_SETUP;
          end else if (r_q.count == ADDR_W'(1)) begin
            r_d.st = ST_IDLE;
            evt[EVT_DONE] = 1'b1;
          end
        end
      end
      ST_SETUP: begin
        // Data already on the pins for a cycle before the strobe
        r_d.strobe = 1'b1;
        r_d.cnt = strobe_cyc;
        r_d.st = ST_STROBE;
      end
      ST_STROBE: begin
        r_d.cnt = r_q.cnt - CNT_W'(1);
        if (r_q.cnt == CNT_W'(1)) begin
          r_d.strobe = 1'b0;
          r_d.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (ack_true) begin
          if (r_q.count == '0) begin
            r_d.st = ST_IDLE;
            evt[EVT_DONE] = 1'b1;
          end else begin
            r_d.st = ST_FETCH;
          end
        end
      end
    endcase

    // Abort from the host
    if (hit && iocmd.clear) begin
      r_d.st = ST_IDLE;
      r_d.strobe = 1'b0;
    end

    // Status edge events
    evt[EVT_OFFLINE] = r_q.online_prev && !online_true;
    evt[EVT_NOPAPER] = !r_q.nopaper_prev && nopaper_true;

    // Read clears, a new event wins over the clear
    if (rd && paddr == OFS_INT_STATUS) begin
      r_d.int_st = '0;
    end
    r_d.int_st = r_d.int_st | evt;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '{st: ST_IDLE, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  logic strobe_active_hi;

  assign strobe_active_hi = sp.strobe_true_hi && !sp.strobe_true_lo;
  assign dma_req = (r_q.st == ST_FETCH);
  assign dma_addr = r_q.addr;
  assign lp_data_pin = sp.data_true_hi ? r_q.chr : ~r_q.chr;
  assign lp_strobe_pin = r_q.strobe ~^ strobe_active_hi;
  assign lp_plot_pin = r_q.plot ~^ sp.plot_true_hi;
  assign irq = |(r_q.int_st & r_q.int_msk);

endmodule : lp_output_if

// ### hw/lp_pkg.sv
// Purpose: Shared constants and types for the line printer output interface
// Assumes: 40 MHz pclk, APB register access, 32-bit data
// Notes: Strap and switch inputs are pin levels, sampled through synchronisers
package lp_pkg;

  // ****************************************************************
  // Clock and strobe timing
  // ****************************************************************
  localparam int CLK_MHZ = 40;
  localparam int STB_NS_0 = 650;  // Narrowest strobe
  localparam int STB_NS_1 = 1300; // Standard strobe
  localparam int STB_NS_2 = 2600;
  localparam int STB_NS_3 = 5200;
  localparam int STB_CYC_0 = (STB_NS_0 * CLK_MHZ + 999) / 1000;
  localparam int STB_CYC_1 = (STB_NS_1 * CLK_MHZ + 999) / 1000;
  localparam int STB_CYC_2 = (STB_NS_2 * CLK_MHZ + 999) / 1000;
  localparam int STB_CYC_3 = (STB_NS_3 * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DMA_ADDR = 8'h08;
  localparam logic [7:0] OFS_DMA_COUNT = 8'h0C;
  localparam logic [7:0] OFS_INT_STATUS = 8'h10;
  localparam logic [7:0] OFS_INT_MASK = 8'h14;
  localparam int ADDR_W = 16;
  localparam int NUM_EVT = 3;
  localparam int EVT_DONE = 0;
  localparam int EVT_OFFLINE = 1;
  localparam int EVT_NOPAPER = 2;

  // ****************************************************************
  // Character codes
  // ****************************************************************
  localparam logic [7:0] CH_LINE_FEED = 8'h0A; // Octal 12
  localparam logic [7:0] CH_CARR_RET = 8'h0D;  // Octal 15
  localparam logic [7:0] CH_VFU_A = 8'h0B;     // Octal 13
  localparam logic [7:0] CH_VFU_B = 8'h12;     // Octal 22
  localparam logic [5:0] DEV_CODE_STD = 6'h0F; // Octal 17

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic data_true_hi;     // Data pins high for a true bit
    logic vfu_code_a;       // Octal 13 is the format command
    logic vfu_code_b;       // Octal 22 is the format command
    logic online_true_hi;
    logic nopaper_true_hi;
    logic strobe_true_lo;
    logic strobe_true_hi;
    logic mask_line_feed;
    logic mask_carr_ret;
    logic mask_vfu_a;
    logic mask_vfu_b;
    logic ack_true_hi;
    logic plot_true_hi;
    logic [3:0] strobe_width; // One-hot width switch
    logic [5:0] dev_switch;   // Switches 3..8, high level = OFF
  } strap_type;

  typedef struct packed {
    logic valid;       // One-cycle instruction pulse
    logic [5:0] code;  // Addressed device code
    logic start;       // Start transfer
    logic clear;       // Abort and clear
  } iocmd_type;

  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_SETUP, ST_STROBE, ST_WAIT
  } lp_state_type;

endpackage : lp_pkg

// ### hw/lp_sync.sv
// Purpose: Two-stage synchroniser for a bundle of pin levels
// Assumes: Each bit is an independent level
// Notes: First stage feeds only the second stage
`timescale 1ns/100ps
module lp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,               // Clock
  input wire logic presetn,            // Async reset, active low
  input wire logic [WIDTH-1:0] async_in, // Pin levels
  output logic [WIDTH-1:0] sync_out    // Synchronised levels
);

  logic [WIDTH-1:0] meta_q;

  // Two flip-flops per bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : lp_sync

// ### test/line_printer_output_interface_tb.sv
// Purpose: Self-checking bench for the line printer output interface
// Assumes: Printer model on the far side, behavioural DMA memory
// Notes: Two strap sets exercise both polarities, both format codes and the masks
`timescale 1ns/100ps
module line_printer_output_interface_tb
  import lp_pkg::*;
;
  // ****************************************************************
  // Signals, design and printer
  // ****************************************************************
  localparam strap_type S1 = {13'h08A8, 4'h1, 6'h0F};
  localparam strap_type S2 = {13'h1757, 4'h8, 6'h2A};
  logic pclk, presetn, psel, penable, pwrite, dma_ack, dma_req, pready, pslverr, irq;
  logic lp_ack_pin, lp_online_pin, lp_nopaper_pin, lp_strobe_pin, lp_plot_pin, got, skip;
  logic [7:0] paddr, lp_data_pin, got_chr, c;
  logic [31:0] pwdata, prdata;
  logic [15:0] dma_rdata, dma_addr;
  logic [63:0] e;
  logic [3:0] pol;
  logic [7:0] mem [16];
  logic [63:0] exp_q [$];
  logic [7:0] chr_q [$];
  iocmd_type iocmd;
  strap_type straps;
  int error_cnt, tests_run, cyc, seed, i;
  lp_output_if dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .iocmd, .dma_req, .dma_addr, .dma_ack, .dma_rdata, .straps, .lp_ack_pin, .lp_online_pin,
    .lp_nopaper_pin, .lp_data_pin, .lp_strobe_pin, .lp_plot_pin, .irq);
  lp_printer_model printer (.pclk, .pol, .data_pin(lp_data_pin), .strobe_pin(lp_strobe_pin),
    .ack_pin(lp_ack_pin), .got, .got_chr);
  // Clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task check(input string n, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask : check
  task results;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  // DMA memory with random latency, result monitor and hang limit
  always @(posedge pclk) begin
    dma_ack <= dma_req && !dma_ack && ($random(seed) % 3 == 0);
    dma_rdata <= {cyc[7:0], mem[dma_addr[3:0]]};
    cyc <= cyc + 1;
    if (got === 1'b1) check("character", got_chr, chr_q.pop_front());
    if (psel && penable && pready && !pwrite) begin
      e = exp_q.pop_front();
      check("register", prdata & e[63:32], e[31:0]);
    end
    if (cyc == 30000) begin
      error_cnt++;
      results();
    end
  end
  // APB transfer; a read notes its expected value and compare mask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    if (!w) exp_q.push_back({m, d});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task cmd(input logic [5:0] code);
    iocmd <= '{1'b1, code, 1'b1, 1'b0};
    @(posedge pclk);
    iocmd <= '0;
  endtask : cmd
  // ****************************************************************
  // One strap set: expected stream, registers, transfer, events
  // ****************************************************************
  task pass(input strap_type s, input logic [7:0] a);
    pol[3] <= 1'b0;
    straps <= s;
    lp_online_pin <= s.online_true_hi;
    lp_nopaper_pin <= !s.nopaper_true_hi;
    repeat (8) @(posedge pclk);
    pol <= {1'b1, s.strobe_true_hi & !s.strobe_true_lo, s.data_true_hi, s.ack_true_hi};
    skip = 1'b0;
    for (i = 0; i < 8; i++) begin
      c = mem[a[3:0] + i[3:0]];
      if (!skip && !(c == CH_LINE_FEED && s.mask_line_feed) && !(c == CH_CARR_RET && s.mask_carr_ret))
        chr_q.push_back(c);
      skip = !skip && (s.mask_vfu_a | s.mask_vfu_b) && c == (s.vfu_code_a ? CH_VFU_A : CH_VFU_B);
    end
    apb(1'b1, OFS_INT_MASK, 32'h7, 32'h0);
    apb(1'b0, OFS_INT_STATUS, 32'h0, 32'h0);
    apb(1'b1, OFS_DMA_ADDR, {24'h0, a}, 32'h0);
    apb(1'b1, OFS_DMA_COUNT, 32'h8, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h1, 32'h0);
    apb(1'b0, OFS_STATUS, {18'h0, s.dev_switch, 8'h04}, 32'h3F0C);
    check("plot", lp_plot_pin, s.plot_true_hi);
    cmd(s.dev_switch ^ 6'h01);
    repeat (4) @(negedge pclk) check("foreign code", dma_req, 1'b0);
    @(posedge pclk);
    cmd(s.dev_switch);
    while (irq !== 1'b1) @(posedge pclk);
    check("left over", chr_q.size(), 32'h0);
    apb(1'b0, OFS_INT_STATUS, 32'h1, 32'h1);
    apb(1'b0, OFS_INT_STATUS, 32'h0, 32'h7);
    @(negedge pclk) check("irq", irq, 1'b0);
    @(posedge pclk);
    lp_online_pin <= !s.online_true_hi;
    lp_nopaper_pin <= s.nopaper_true_hi;
    repeat (6) @(posedge pclk);
    apb(1'b0, OFS_INT_STATUS, 32'h6, 32'h7);
  endtask : pass
  // Main sequence
  initial begin
    seed = 65872;
    error_cnt = 0;
    tests_run = 0;
    cyc = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata, iocmd, dma_ack, dma_rdata, pol} = '0;
    straps = S1;
    lp_online_pin = 1'b0;
    lp_nopaper_pin = 1'b1;
    mem = '{8'h41, 8'h0A, 8'h0B, 8'h55, 8'h0D, 8'h12, 8'h40, 8'h0A,
            8'h0D, 8'h0A, 8'h12, 8'h33, 8'h0B, 8'h40, 8'h0D, 8'h7E};
    mem[6] = 8'h40 | (8'h3F & $random(seed));
    mem[13] = 8'h40 | (8'h3F & $random(seed));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    pass(S1, 8'h00);
    pass(S2, 8'h08);
    // Abort: start again, clear from the host while the printer is still busy
    chr_q.push_back(8'h0A);
    apb(1'b1, OFS_DMA_ADDR, 32'h8, 32'h0);
    apb(1'b1, OFS_DMA_COUNT, 32'h8, 32'h0);
    cmd(S2.dev_switch);
    while (got !== 1'b1) @(posedge pclk);
    while (lp_strobe_pin !== 1'b0) @(posedge pclk);
    iocmd <= '{1'b1, S2.dev_switch, 1'b0, 1'b1};
    @(posedge pclk);
    iocmd <= '0;
    apb(1'b0, OFS_STATUS, 32'h0, 32'h2);
    apb(1'b0, OFS_DMA_ADDR, 32'hA, 32'hFFFF);
    apb(1'b0, 8'h40, 32'h0, 32'hFFFFFFFF);
    results();
  end
endmodule : line_printer_output_interface_tb

// ### test/lp_output_if_chk.sv
// Purpose: Port-level checks of the line printer output interface
// Assumes: Strap pins change only while the printer side is idle
// Notes: Checks pause for a settling spell after reset or a strap change
`timescale 1ns/100ps
module lp_output_if_chk
  import lp_pkg::*;
(
  input wire logic pclk,                   // Clock
  input wire logic presetn,                // Async reset, active low
  input wire logic psel,                   // APB select
  input wire logic penable,                // APB enable
  input wire logic pwrite,                 // APB direction
  input wire logic [7:0] paddr,            // APB address
  input wire logic [31:0] prdata,          // APB read data
  input wire logic pslverr,                // APB error
  input wire logic dma_req,                // DMA request
  input wire logic dma_ack,                // DMA data valid
  input wire logic [ADDR_W-1:0] dma_addr,  // DMA address
  input wire strap_type straps,            // Strap pins
  input wire logic lp_ack_pin,             // Printer acknowledge
  input wire logic [7:0] lp_data_pin,      // Printer data
  input wire logic lp_strobe_pin,          // Printer strobe
  input wire logic irq                     // Interrupt
);
  // ****************************************************************
  // Helper state
  // ****************************************************************
  strap_type straps_q;
  logic [3:0] settle_q;
  logic [8:0] run_q;
  logic ack_seen_q;
  logic strobe_act;
  logic ack_true;
  logic [7:0] data_true;
  int expw;
  // Pin levels turned into true values by the straps
  assign strobe_act = (straps.strobe_true_hi & ~straps.strobe_true_lo) ~^ lp_strobe_pin;
  assign ack_true = straps.ack_true_hi ~^ lp_ack_pin;
  assign data_true = straps.data_true_hi ? lp_data_pin : ~lp_data_pin;
  assign expw = straps.strobe_width[0] ? STB_CYC_0 : straps.strobe_width[2] ? STB_CYC_2 :
                straps.strobe_width[3] ? STB_CYC_3 : STB_CYC_1;
  // Settling spell, strobe length so far, acknowledge seen since the last strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      straps_q <= '0;
      settle_q <= 4'hF;
      run_q <= '0;
      ack_seen_q <= 1'b0;
    end else begin
      straps_q <= straps;
      settle_q <= (straps != straps_q) ? 4'hF : (settle_q != 4'h0) ? settle_q - 4'h1 : 4'h0;
      run_q <= strobe_act ? run_q + 9'h1 : 9'h0;
      ack_seen_q <= strobe_act ? 1'b0 : (ack_seen_q | ack_true);
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn || settle_q != 4'h0);
  // ****************************************************************
  // Assertions and covers
  // ****************************************************************
  a_strobe_width_exact: assert property ($fell(strobe_act) |-> run_q == expw)
    else $error("strobe width wrong");
  a_data_held_strobe: assert property (strobe_act ##1 strobe_act |-> $stable(lp_data_pin))
    else $error("data moved during strobe");
  a_data_before_strobe: assert property ($rose(strobe_act) |-> $stable(lp_data_pin))
    else $error("data not set up before strobe");
  a_ack_before_next: assert property ($rose(strobe_act) |-> ack_seen_q)
    else $error("strobe without acknowledge");
  a_line_feed_masked: assert property (strobe_act && straps.mask_line_feed |-> data_true != CH_LINE_FEED)
    else $error("masked line feed sent");
  a_carr_ret_masked: assert property (strobe_act && straps.mask_carr_ret |-> data_true != CH_CARR_RET)
    else $error("masked carriage return sent");
  a_dma_req_holds: assert property (dma_req && !dma_ack |=> dma_req && $stable(dma_addr))
    else $error("dma request dropped early");
  a_no_strobe_fetching: assert property (dma_req |-> !strobe_act)
    else $error("strobe while fetching");
  a_unmapped_error: assert property (psel && penable && paddr > OFS_INT_MASK |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  c_strobe: cover property ($fell(strobe_act));
  c_irq: cover property ($rose(irq));
  c_error: cover property (psel && penable && pslverr);
endmodule : lp_output_if_chk

bind lp_output_if lp_output_if_chk chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pslverr,
  .dma_req, .dma_ack, .dma_addr, .straps, .lp_ack_pin, .lp_data_pin, .lp_strobe_pin, .irq);

// ### test/lp_printer_model.sv
// Purpose: Behavioural parallel printer on the far side of the interface
// Assumes: The bench hands in the strap polarities once the straps have settled
// Notes: Alternates a quick and a slow acknowledge after each character
`timescale 1ns/100ps
module lp_printer_model (
  input wire logic pclk,            // Clock
  input wire logic [3:0] pol,       // Enable, strobe high, data high, ack high
  input wire logic [7:0] data_pin,  // Printer data pins
  input wire logic strobe_pin,      // Printer strobe pin
  output logic ack_pin,             // Acknowledge pin
  output logic got,                 // One-cycle pulse per character taken
  output logic [7:0] got_chr        // Character taken, true levels
);
  // ****************************************************************
  // Strobe capture and acknowledge
  // ****************************************************************
  logic act;
  logic act_q = 1'b0;
  logic ready = 1'b1;
  logic slow = 1'b0;
  int wait_cnt = 0;
  // Disabled while polarities are being changed, so a settling pin is not a strobe
  assign act = pol[3] && (strobe_pin == pol[2]);
  assign ack_pin = ready ~^ pol[0];
  // Take the character at the strobe, then stay busy a short or a long while
  always @(posedge pclk) begin
    act_q <= act;
    got <= act && !act_q;
    if (act && !act_q) begin
      got_chr <= pol[1] ? data_pin : ~data_pin;
      ready <= 1'b0;
      slow <= !slow;
      wait_cnt <= slow ? 30 : 3;
    end else if (!act && wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end else if (!act) begin
      ready <= 1'b1;
    end
  end
endmodule : lp_printer_model
